/* File: rtl/bbe_pkg.sv */
package bbe_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_DERIVATIVE_CODE = 8'had;
   localparam logic [7:0] ADDR_FAMILY_CODE     = 8'hb5;
   localparam logic [7:0] ADDR_REVISION_CODE   = 8'hb6;
   localparam logic [7:0] ADDR_SECOND_ACC      = 8'hf0;
   localparam logic [7:0] RST_SECOND_ACC       = 8'h00;

   // bit addresses of the second accumulator: upper five bits match
   localparam logic [4:0] BITADDR_SECOND_ACC   = 5'h1e;

   // ---------------------------------------------------------------
   // instruction lengths in bytes
   // ---------------------------------------------------------------
   localparam logic [1:0] LEN_1 = 2'h1;
   localparam logic [1:0] LEN_2 = 2'h2;
   localparam logic [1:0] LEN_3 = 2'h3;

   // ---------------------------------------------------------------
   // base cycle counts; a taken conditional branch adds one
   // ---------------------------------------------------------------
   localparam logic [2:0] CYC_BIT       = 3'h2;
   localparam logic [2:0] CYC_BR_SHORT  = 3'h2;
   localparam logic [2:0] CYC_BR_BIT    = 3'h3;
   localparam logic [2:0] CYC_SHORT_JUMP = 3'h3;
   localparam logic [2:0] CYC_JUMP_IND  = 3'h3;
   localparam logic [2:0] CYC_CMP_DIR   = 3'h4;
   localparam logic [2:0] CYC_CMP_IMM   = 3'h3;
   localparam logic [2:0] CYC_CMP_REG   = 3'h3;
   localparam logic [2:0] CYC_CMP_IND   = 3'h4;
   localparam logic [2:0] CYC_DEC_REG   = 3'h2;
   localparam logic [2:0] CYC_DEC_DIR   = 3'h3;
   localparam logic [2:0] CYC_TAKEN_ADD = 3'h1;

   // ---------------------------------------------------------------
   // operations
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_AND_BIT      = 5'h00,
      OP_AND_NBIT     = 5'h01,
      OP_OR_BIT       = 5'h02,
      OP_OR_NBIT      = 5'h03,
      OP_COPY_BIT_C   = 5'h04,
      OP_COPY_C_BIT   = 5'h05,
      OP_BR_CARRY     = 5'h06,
      OP_BR_NO_CARRY  = 5'h07,
      OP_BR_BIT_SET   = 5'h08,
      OP_BR_BIT_CLEAR = 5'h09,
      OP_BR_CLR_BIT   = 5'h0a,
      OP_SHORT_JUMP   = 5'h0b,
      OP_IND_JUMP     = 5'h0c,
      OP_BR_ACC_ZERO  = 5'h0d,
      OP_BR_ACC_NZERO = 5'h0e,
      OP_CMP_ACC_DIR  = 5'h0f,
      OP_CMP_ACC_IMM  = 5'h10,
      OP_CMP_REG_IMM  = 5'h11,
      OP_CMP_IND_IMM  = 5'h12,
      OP_DEC_REG      = 5'h13,
      OP_DEC_DIR      = 5'h14
   } bbe_op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } bbe_state_t;

endpackage

/* File: rtl/bbe_core.sv */
`timescale 1ns/1ps

// Functional notes
// - AND addressed bit into carry, 2B/2cyc
// - AND inverted bit into carry, 2B/2cyc
// - OR bit or inverse into carry
// - copy bit to carry, carry to bit
// - branch on carry set/clear, 2/3 cyc
// - branch on bit set/clear, 3/4 cyc
// - branch-and-clear clears bit when taken
// - short jump: pc plus signed offset, 3cyc
// - indirect jump to acc plus data_pointer
// - branch on accumulator zero/nonzero, 2/3 cyc
// - compare acc with direct, 4/5 cyc
// - compare acc with immediate, 3/4 cyc
// - compare register with immediate, 3/4 cyc
// - compare indirect with immediate, 4/5 cyc
// - decrement register, branch nonzero, 2/3 cyc
// - decrement direct, branch nonzero, 3/4 cyc
// - second accumulator rw at 0xf0, reset 0
// - three read-only identification registers
// - family code read-only at 0xb5
module bbe_core #(
   parameter logic [7:0] FAMILY_CODE     = 8'h5a, // arbitrary value
   parameter logic [7:0] DERIVATIVE_CODE = 8'h01, // arbitrary value
   parameter logic [7:0] REVISION_CODE   = 8'h02  // arbitrary value
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             reset_n,
   // register port
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [7:0]       reg_rdata,
   // instruction issue
   input  wire logic             op_start,
   input  wire bbe_pkg::bbe_op_t op_code,
   input  wire logic [7:0]       op_bit_addr,
   input  wire logic             op_bit_val,
   input  wire logic             op_carry,
   input  wire logic [7:0]       op_acc,
   input  wire logic [7:0]       op_dir_byte,
   input  wire logic [7:0]       op_imm,
   input  wire logic [7:0]       op_ind_byte,
   input  wire logic [7:0]       op_reg_byte,
   input  wire logic [7:0]       op_rel,
   input  wire logic [15:0]      op_pc,
   input  wire logic [15:0]      op_data_pointer,
   // results
   output logic                  busy,
   output logic                  done,
   output logic                  carry,
   output logic                  taken,
   output logic      [15:0]      next_pc,
   output logic      [2:0]       cycles,
   output logic      [1:0]       length,
   output logic                  bit_wr,
   output logic      [7:0]       bit_waddr,
   output logic                  bit_wdata,
   output logic                  byte_wr,
   output logic      [7:0]       byte_wdata
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   bbe_pkg::bbe_state_t state_ff;
   bbe_pkg::bbe_state_t nxt_state;
   logic [2:0]  cnt_ff;
   logic [7:0]  second_acc_ff;
   logic [7:0]  rdata_ff;
   logic        done_ff;
   logic        carry_ff;
   logic        taken_ff;
   logic [15:0] pc_ff;
   logic [2:0]  cycles_ff;
   logic [1:0]  length_ff;
   logic        bit_wr_ff;
   logic [7:0]  bit_waddr_ff;
   logic        bit_wdata_ff;
   logic        byte_wr_ff;
   logic [7:0]  byte_wdata_ff;
   // staged results, published together with done
   logic        st_carry_ff;
   logic        st_taken_ff;
   logic [15:0] st_pc_ff;
   logic [2:0]  st_cycles_ff;
   logic [1:0]  st_length_ff;
   logic        st_bit_wr_ff;
   logic        st_bit_val_ff;
   logic        st_byte_wr_ff;
   logic [7:0]  st_byte_ff;
   logic [7:0]  st_bit_addr_ff;

   // ---------------------------------------------------------------
   // operand selection
   // ---------------------------------------------------------------
   wire        bit_in_acc2 = (op_bit_addr[7:3] == bbe_pkg::BITADDR_SECOND_ACC);
   wire        src_bit     = bit_in_acc2 ? second_acc_ff[op_bit_addr[2:0]] : op_bit_val;
   wire [7:0]  dec_src     = (op_code == bbe_pkg::OP_DEC_REG) ? op_reg_byte : op_dir_byte;
   wire [7:0]  dec_res     = dec_src - 8'h01;
   wire [15:0] rel_ext     = {{8{op_rel[7]}}, op_rel};
   wire        start_ok    = op_start && (state_ff == bbe_pkg::ST_IDLE);

   // ---------------------------------------------------------------
   // decode: length, base cycles, condition, results
   // ---------------------------------------------------------------
   logic [1:0]  dec_len;
   logic [2:0]  dec_cyc;
   logic        dec_cond;
   logic        dec_is_br;
   logic        dec_carry;
   logic        dec_bit_wr;
   logic        dec_bit_val;
   logic        dec_byte_wr;

   always_comb begin
      dec_len     = bbe_pkg::LEN_2;
      dec_cyc     = bbe_pkg::CYC_BIT;
      dec_cond    = 1'b0;
      dec_is_br   = 1'b1;
      dec_carry   = op_carry;
      dec_bit_wr  = 1'b0;
      dec_bit_val = 1'b0;
      dec_byte_wr = 1'b0;
      unique case (op_code)
         bbe_pkg::OP_AND_BIT: begin
            dec_is_br = 1'b0;
            dec_carry = op_carry & src_bit;
         end
         bbe_pkg::OP_AND_NBIT: begin
            dec_is_br = 1'b0;
            dec_carry = op_carry & ~src_bit;
         end
         bbe_pkg::OP_OR_BIT: begin
            dec_is_br = 1'b0;
            dec_carry = op_carry | src_bit;
         end
         bbe_pkg::OP_OR_NBIT: begin
            dec_is_br = 1'b0;
            dec_carry = op_carry | ~src_bit;
         end
         bbe_pkg::OP_COPY_BIT_C: begin
            dec_is_br = 1'b0;
            dec_carry = src_bit;
         end
         bbe_pkg::OP_COPY_C_BIT: begin
            dec_is_br   = 1'b0;
            dec_bit_wr  = 1'b1;
            dec_bit_val = op_carry;
         end
         bbe_pkg::OP_BR_CARRY: begin
            dec_cyc  = bbe_pkg::CYC_BR_SHORT;
            dec_cond = op_carry;
         end
         bbe_pkg::OP_BR_NO_CARRY: begin
            dec_cyc  = bbe_pkg::CYC_BR_SHORT;
            dec_cond = ~op_carry;
         end
         bbe_pkg::OP_BR_BIT_SET: begin
            dec_len  = bbe_pkg::LEN_3;
            dec_cyc  = bbe_pkg::CYC_BR_BIT;
            dec_cond = src_bit;
         end
         bbe_pkg::OP_BR_BIT_CLEAR: begin
            dec_len  = bbe_pkg::LEN_3;
            dec_cyc  = bbe_pkg::CYC_BR_BIT;
            dec_cond = ~src_bit;
         end
         bbe_pkg::OP_BR_CLR_BIT: begin
            dec_len     = bbe_pkg::LEN_3;
            dec_cyc     = bbe_pkg::CYC_BR_BIT;
            dec_cond    = src_bit;
            dec_bit_wr  = src_bit;
            dec_bit_val = 1'b0;
         end
         bbe_pkg::OP_SHORT_JUMP: begin
            dec_cyc   = bbe_pkg::CYC_SHORT_JUMP;
            dec_is_br = 1'b0;
         end
         bbe_pkg::OP_IND_JUMP: begin
            dec_len   = bbe_pkg::LEN_1;
            dec_cyc   = bbe_pkg::CYC_JUMP_IND;
            dec_is_br = 1'b0;
         end
         bbe_pkg::OP_BR_ACC_ZERO: begin
            dec_cyc  = bbe_pkg::CYC_BR_SHORT;
            dec_cond = (op_acc == 8'h00);
         end
         bbe_pkg::OP_BR_ACC_NZERO: begin
            dec_cyc  = bbe_pkg::CYC_BR_SHORT;
            dec_cond = (op_acc != 8'h00);
         end
         bbe_pkg::OP_CMP_ACC_DIR: begin
            dec_len  = bbe_pkg::LEN_3;
            dec_cyc  = bbe_pkg::CYC_CMP_DIR;
            dec_cond = (op_acc != op_dir_byte);
         end
         bbe_pkg::OP_CMP_ACC_IMM: begin
            dec_len  = bbe_pkg::LEN_3;
            dec_cyc  = bbe_pkg::CYC_CMP_IMM;
            dec_cond = (op_acc != op_imm);
         end
         bbe_pkg::OP_CMP_REG_IMM: begin
            dec_len  = bbe_pkg::LEN_3;
            dec_cyc  = bbe_pkg::CYC_CMP_REG;
            dec_cond = (op_reg_byte != op_imm);
         end
         bbe_pkg::OP_CMP_IND_IMM: begin
            dec_len  = bbe_pkg::LEN_3;
            dec_cyc  = bbe_pkg::CYC_CMP_IND;
            dec_cond = (op_ind_byte != op_imm);
         end
         bbe_pkg::OP_DEC_REG: begin
            dec_cyc     = bbe_pkg::CYC_DEC_REG;
            dec_cond    = (dec_res != 8'h00);
            dec_byte_wr = 1'b1;
         end
         bbe_pkg::OP_DEC_DIR: begin
            dec_len     = bbe_pkg::LEN_3;
            dec_cyc     = bbe_pkg::CYC_DEC_DIR;
            dec_cond    = (dec_res != 8'h00);
            dec_byte_wr = 1'b1;
         end
         default: begin
            dec_is_br = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // target and total cycle count
   // ---------------------------------------------------------------
   wire        is_jump    = (op_code == bbe_pkg::OP_SHORT_JUMP) ||
                            (op_code == bbe_pkg::OP_IND_JUMP);
   wire        dec_taken  = (dec_is_br && dec_cond) || is_jump;
   wire [15:0] fall_pc    = op_pc + {14'h0000, dec_len};
   wire [15:0] rel_pc     = fall_pc + rel_ext;
   wire [15:0] ind_pc     = op_data_pointer + {8'h00, op_acc};
   wire [15:0] dec_pc     = (op_code == bbe_pkg::OP_IND_JUMP) ? ind_pc :
                            dec_taken ? rel_pc : fall_pc;
   // a taken conditional branch costs one extra cycle for the refetch
   wire [2:0]  dec_total  = (dec_is_br && dec_cond) ? dec_cyc + bbe_pkg::CYC_TAKEN_ADD
                                                    : dec_cyc;
   wire        last_cyc   = (state_ff == bbe_pkg::ST_EXEC) && (cnt_ff == 3'h1);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         bbe_pkg::ST_IDLE: begin
            if (start_ok) begin
               nxt_state = bbe_pkg::ST_EXEC;
            end
         end
         bbe_pkg::ST_EXEC: begin
            if (last_cyc) begin
               nxt_state = bbe_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_state = bbe_pkg::ST_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= bbe_pkg::ST_IDLE;
         cnt_ff   <= 3'h0;
      end else begin
         state_ff <= nxt_state;
         if (start_ok) begin
            cnt_ff <= dec_total;
         end else if (state_ff == bbe_pkg::ST_EXEC) begin
            cnt_ff <= cnt_ff - 3'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_carry_ff    <= 1'b0;
         st_taken_ff    <= 1'b0;
         st_pc_ff       <= 16'h0000;
         st_cycles_ff   <= 3'h0;
         st_length_ff   <= 2'h0;
         st_bit_wr_ff   <= 1'b0;
         st_bit_val_ff  <= 1'b0;
         st_byte_wr_ff  <= 1'b0;
         st_byte_ff     <= 8'h00;
         st_bit_addr_ff <= 8'h00;
      end else if (start_ok) begin
         st_carry_ff    <= dec_carry;
         st_taken_ff    <= dec_taken;
         st_pc_ff       <= dec_pc;
         st_cycles_ff   <= dec_total;
         st_length_ff   <= dec_len;
         st_bit_wr_ff   <= dec_bit_wr;
         st_bit_val_ff  <= dec_bit_val;
         st_byte_wr_ff  <= dec_byte_wr;
         st_byte_ff     <= dec_res;
         st_bit_addr_ff <= op_bit_addr;
      end
   end

   // results publish on the final cycle so done marks the true latency
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         done_ff       <= 1'b0;
         carry_ff      <= 1'b0;
         taken_ff      <= 1'b0;
         pc_ff         <= 16'h0000;
         cycles_ff     <= 3'h0;
         length_ff     <= 2'h0;
         bit_wr_ff     <= 1'b0;
         bit_waddr_ff  <= 8'h00;
         bit_wdata_ff  <= 1'b0;
         byte_wr_ff    <= 1'b0;
         byte_wdata_ff <= 8'h00;
      end else begin
         done_ff    <= last_cyc;
         bit_wr_ff  <= last_cyc && st_bit_wr_ff;
         byte_wr_ff <= last_cyc && st_byte_wr_ff;
         if (last_cyc) begin
            carry_ff      <= st_carry_ff;
            taken_ff      <= st_taken_ff;
            pc_ff         <= st_pc_ff;
            cycles_ff     <= st_cycles_ff;
            length_ff     <= st_length_ff;
            bit_waddr_ff  <= st_bit_addr_ff;
            bit_wdata_ff  <= st_bit_val_ff;
            byte_wdata_ff <= st_byte_ff;
         end
      end
   end

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   wire       wr_acc2   = reg_wr && (reg_addr == bbe_pkg::ADDR_SECOND_ACC);
   wire       bit_acc2  = last_cyc && st_bit_wr_ff &&
                          (st_bit_addr_ff[7:3] == bbe_pkg::BITADDR_SECOND_ACC);
   // a bit write from the core lands on top of a same-cycle bus write
   logic [7:0] acc2_bitmask;
   always_comb begin
      acc2_bitmask = 8'h00;
      acc2_bitmask[st_bit_addr_ff[2:0]] = bit_acc2;
   end
   wire [7:0] acc2_base = wr_acc2 ? reg_wdata : second_acc_ff;
   wire [7:0] nxt_acc2  = (acc2_base & ~acc2_bitmask) |
                          ({8{st_bit_val_ff}} & acc2_bitmask);

   // identification codes have no write path at all
   wire [7:0] rd_mux = (reg_addr == bbe_pkg::ADDR_SECOND_ACC)      ? second_acc_ff   :
                       (reg_addr == bbe_pkg::ADDR_FAMILY_CODE)     ? FAMILY_CODE     :
                       (reg_addr == bbe_pkg::ADDR_DERIVATIVE_CODE) ? DERIVATIVE_CODE :
                       (reg_addr == bbe_pkg::ADDR_REVISION_CODE)   ? REVISION_CODE   :
                       8'h00;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         second_acc_ff <= bbe_pkg::RST_SECOND_ACC;
         rdata_ff      <= 8'h00;
      end else begin
         second_acc_ff <= nxt_acc2;
         rdata_ff      <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign reg_rdata  = rdata_ff;
   assign busy       = state_ff[1];
   assign done       = done_ff;
   assign carry      = carry_ff;
   assign taken      = taken_ff;
   assign next_pc    = pc_ff;
   assign cycles     = cycles_ff;
   assign length     = length_ff;
   assign bit_wr     = bit_wr_ff;
   assign bit_waddr  = bit_waddr_ff;
   assign bit_wdata  = bit_wdata_ff;
   assign byte_wr    = byte_wr_ff;
   assign byte_wdata = byte_wdata_ff;

endmodule

/* File: sim/bbe_core_properties.sv */
`timescale 1ns/1ps
module bbe_core_properties #(
   parameter logic [7:0] FAMILY_CODE = 8'h5a
) (
   // clock and reset
   input wire logic             mclk,
   input wire logic             reset_n,
   // register port
   input wire logic [7:0]       reg_addr,
   input wire logic [7:0]       reg_wdata,
   input wire logic             reg_wr,
   input wire logic             reg_rd,
   input wire logic [7:0]       reg_rdata,
   // execute port
   input wire logic             op_start,
   input wire bbe_pkg::bbe_op_t op_code,
   input wire logic             busy,
   input wire logic             done,
   input wire logic             taken,
   input wire logic [2:0]       cycles,
   input wire logic [1:0]       length,
   input wire logic             bit_wr
);
   // ---------------------------------------------------------------
   // helper: busy cycles and operation of the running instruction
   // ---------------------------------------------------------------
   logic [3:0]       busy_cnt_ff;
   bbe_pkg::bbe_op_t op_ff;
   wire              start_ok = op_start && !busy;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         busy_cnt_ff <= 4'h0;
         op_ff       <= bbe_pkg::OP_AND_BIT;
      end else if (start_ok) begin
         busy_cnt_ff <= 4'h0;
         op_ff       <= op_code;
      end else if (busy) begin
         busy_cnt_ff <= busy_cnt_ff + 4'h1;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   sequence s_acc_read;
      reg_rd && reg_addr == bbe_pkg::ADDR_SECOND_ACC;
   endsequence
   property p_acc_readback;
      logic [7:0] d;
      (reg_wr && reg_addr == bbe_pkg::ADDR_SECOND_ACC, d = reg_wdata) ##1 (s_acc_read && !bit_wr)
         |=> reg_rdata == d;
   endproperty
   a_busy_after_start: assert property (start_ok |=> busy)
      else $error("busy did not follow an accepted start");
   a_done_one_cycle: assert property (done |=> !done)
      else $error("done longer than one cycle");
   a_done_ends_busy: assert property ($fell(busy) |-> done)
      else $error("busy fell without done");
   a_cycle_count_match: assert property (done |-> busy_cnt_ff == {1'b0, cycles})
      else $error("busy cycles differ from reported cycles");
   a_jump_always_taken: assert property (done && (op_ff == bbe_pkg::OP_SHORT_JUMP ||
         op_ff == bbe_pkg::OP_IND_JUMP) |-> taken && cycles == 3'h3)
      else $error("jump not taken in three cycles");
   a_bit_op_timing: assert property (done && op_ff <= bbe_pkg::OP_COPY_C_BIT
         |-> cycles == 3'h2 && length == 2'h2 && !taken)
      else $error("bit operation timing wrong");
   a_taken_adds_one: assert property (done && (op_ff == bbe_pkg::OP_BR_CARRY ||
         op_ff == bbe_pkg::OP_BR_NO_CARRY) |-> cycles == (taken ? 3'h3 : 3'h2))
      else $error("carry branch cycles wrong");
   a_acc_readback: assert property (p_acc_readback)
      else $error("second accumulator readback wrong");
   a_family_code_read: assert property (reg_rd && reg_addr == bbe_pkg::ADDR_FAMILY_CODE
         |=> reg_rdata == FAMILY_CODE)
      else $error("family code read wrong");
   a_bit_wr_with_done: assert property (bit_wr |-> done)
      else $error("bit write outside done");
endmodule

bind bbe_core bbe_core_properties #(.FAMILY_CODE(FAMILY_CODE)) u_props (.*);

/* File: sim/bbe_core_test.sv */
`timescale 1ns/1ps
module bbe_core_test;
   localparam logic [7:0] FAMILY = 8'h3c; // arbitrary value
   localparam logic [7:0] DERIV  = 8'h17; // arbitrary value
   localparam logic [7:0] REV    = 8'h09; // arbitrary value
   localparam int         LIMIT  = 4000;
   localparam logic [2:0] CY [0:20] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h3,
      3'h3, 3'h3, 3'h3, 3'h3, 3'h2, 3'h2, 3'h4, 3'h3, 3'h3, 3'h4, 3'h2, 3'h3};
   localparam logic [1:0] LN [0:20] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3,
      2'h3, 2'h3, 2'h2, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h3};
   logic mclk, reset_n, reg_wr, reg_rd, op_start, op_bit_val, op_carry;
   logic busy, done, carry, taken, bit_wr, bit_wdata, byte_wr;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, op_bit_addr, op_acc, op_dir_byte, op_imm;
   logic [7:0] op_ind_byte, op_reg_byte, op_rel, bit_waddr, byte_wdata, acc_model;
   logic [15:0] op_pc, op_data_pointer, next_pc;
   logic [2:0] cycles;
   logic [1:0] length;
   bbe_pkg::bbe_op_t op_code;
   int failures, samples_checked, cyc_cnt;

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   bbe_core #(.FAMILY_CODE(FAMILY), .DERIVATIVE_CODE(DERIV), .REVISION_CODE(REV)) DUT (
      .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_start(op_start),
      .op_code(op_code), .op_bit_addr(op_bit_addr), .op_bit_val(op_bit_val),
      .op_carry(op_carry), .op_acc(op_acc), .op_dir_byte(op_dir_byte), .op_imm(op_imm),
      .op_ind_byte(op_ind_byte), .op_reg_byte(op_reg_byte), .op_rel(op_rel), .op_pc(op_pc),
      .op_data_pointer(op_data_pointer), .busy(busy), .done(done), .carry(carry),
      .taken(taken), .next_pc(next_pc), .cycles(cycles), .length(length), .bit_wr(bit_wr),
      .bit_waddr(bit_waddr), .bit_wdata(bit_wdata), .byte_wr(byte_wr), .byte_wdata(byte_wdata));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // the next bus task lowers the write strobe, so a write is always followed by a read
   task automatic reg_write(logic [7:0] a, logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
   endtask

   task automatic reg_read(logic [7:0] a, logic [7:0] exp);
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      check("reg_rdata", reg_rdata, exp);
   endtask

   task automatic exec(bbe_pkg::bbe_op_t op, logic dbl);
      logic b, ec, et, ebw, eb, eyw;
      logic [15:0] epc;
      logic [2:0] ecy;
      logic [7:0] edec;
      int nb;
      @(posedge mclk);
      op_code <= op;
      op_start <= 1'b1;
      #1;
      b = (op_bit_addr[7:3] == bbe_pkg::BITADDR_SECOND_ACC) ? acc_model[op_bit_addr[2:0]]
         : op_bit_val;
      {ec, et, ebw, eb} = {op_carry, 1'b0, 1'b0, op_carry};
      eyw = (op == bbe_pkg::OP_DEC_REG || op == bbe_pkg::OP_DEC_DIR);
      edec = ((op == bbe_pkg::OP_DEC_REG) ? op_reg_byte : op_dir_byte) - 8'h01;
      case (op)
         bbe_pkg::OP_AND_BIT:      ec = op_carry & b;
         bbe_pkg::OP_AND_NBIT:     ec = op_carry & ~b;
         bbe_pkg::OP_OR_BIT:       ec = op_carry | b;
         bbe_pkg::OP_OR_NBIT:      ec = op_carry | ~b;
         bbe_pkg::OP_COPY_BIT_C:   ec = b;
         bbe_pkg::OP_COPY_C_BIT:   ebw = 1'b1;
         bbe_pkg::OP_BR_CARRY:     et = op_carry;
         bbe_pkg::OP_BR_NO_CARRY:  et = ~op_carry;
         bbe_pkg::OP_BR_BIT_SET:   et = b;
         bbe_pkg::OP_BR_BIT_CLEAR: et = ~b;
         bbe_pkg::OP_BR_CLR_BIT:   {et, ebw, eb} = {b, b, 1'b0};
         bbe_pkg::OP_BR_ACC_ZERO:  et = (op_acc == 8'h00);
         bbe_pkg::OP_BR_ACC_NZERO: et = (op_acc != 8'h00);
         bbe_pkg::OP_CMP_ACC_DIR:  et = (op_acc != op_dir_byte);
         bbe_pkg::OP_CMP_ACC_IMM:  et = (op_acc != op_imm);
         bbe_pkg::OP_CMP_REG_IMM:  et = (op_reg_byte != op_imm);
         bbe_pkg::OP_CMP_IND_IMM:  et = (op_ind_byte != op_imm);
         bbe_pkg::OP_DEC_REG, bbe_pkg::OP_DEC_DIR: et = (edec != 8'h00);
         default:                  et = 1'b1;
      endcase
      ecy = CY[op] + ((et && op != bbe_pkg::OP_SHORT_JUMP && op != bbe_pkg::OP_IND_JUMP)
         ? 3'h1 : 3'h0);
      epc = op_pc + LN[op] + (et ? {{8{op_rel[7]}}, op_rel} : 16'h0000);
      if (op == bbe_pkg::OP_IND_JUMP)
         epc = op_data_pointer + op_acc;
      if (ebw && op_bit_addr[7:3] == bbe_pkg::BITADDR_SECOND_ACC)
         acc_model[op_bit_addr[2:0]] = eb;
      @(posedge mclk);
      op_start <= dbl;
      nb = 0;
      for (int i = 0; i < 12; i++) begin
         #1;
         if (done === 1'b1)
            break;
         if (busy === 1'b1)
            nb++;
         @(posedge mclk);
         op_start <= 1'b0;
      end
      check("done", done, 1'b1);
      check("carry", carry, ec);
      check("taken", taken, et);
      check("next_pc", next_pc, epc);
      check("cycles", cycles, ecy);
      check("busy cycles", 16'(nb), ecy);
      check("length", length, LN[op]);
      check("bit_wr", bit_wr, ebw);
      if (ebw)
         check("bit write", {bit_waddr, bit_wdata}, {op_bit_addr, eb});
      check("byte_wr", byte_wr, eyw);
      if (eyw)
         check("byte_wdata", byte_wdata, edec);
      if (dbl)
         repeat (6) begin
            @(posedge mclk);
            #1;
            check("second done", done, 1'b0);
         end
   endtask

   // ---------------------------------------------------------------
   // run
   // ---------------------------------------------------------------
   always @(posedge mclk) begin
      cyc_cnt++;
      if (cyc_cnt == LIMIT) begin
         failures++;
         $display("timeout after %0d cycles", cyc_cnt);
         summarize();
      end
   end

   initial begin
      {reset_n, reg_wr, reg_rd, op_start, op_bit_val, op_carry} = 6'h00;
      {reg_addr, reg_wdata, op_acc, op_dir_byte, op_imm, op_ind_byte} = 48'h0;
      {op_reg_byte, op_rel, op_pc, op_data_pointer} = 48'h0;
      op_code = bbe_pkg::OP_AND_BIT;
      op_bit_addr = 8'h20;
      acc_model = bbe_pkg::RST_SECOND_ACC;
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      reg_read(bbe_pkg::ADDR_SECOND_ACC, 8'h00);
      reg_read(bbe_pkg::ADDR_FAMILY_CODE, FAMILY);
      reg_read(bbe_pkg::ADDR_DERIVATIVE_CODE, DERIV);
      reg_read(bbe_pkg::ADDR_REVISION_CODE, REV);
      reg_write(bbe_pkg::ADDR_FAMILY_CODE, 8'hff);
      reg_read(bbe_pkg::ADDR_FAMILY_CODE, FAMILY);
      reg_write(bbe_pkg::ADDR_SECOND_ACC, 8'ha5);
      reg_read(bbe_pkg::ADDR_SECOND_ACC, 8'ha5);
      reg_write(8'h80, 8'h11);
      reg_read(8'h80, 8'h00);
      acc_model = 8'ha5;
      $display("test registers done");
      // last pass addresses a second accumulator bit, so bit writes land in the register
      for (int k = 0; k < 4; k++) begin
         for (int o = 0; o <= 20; o++) begin
            @(posedge mclk);
            op_bit_val <= k[0];
            op_carry <= k[1];
            op_acc <= k[0] ? 8'h00 : 8'h3c;
            op_dir_byte <= k[1] ? 8'h3c : 8'h01;
            op_imm <= 8'h3c;
            op_reg_byte <= k[0] ? 8'h01 : 8'h80;
            op_ind_byte <= k[1] ? 8'h3c : 8'h00;
            op_rel <= k[0] ? 8'hfc : 8'h05;
            op_pc <= 16'h1234 + 16'(k);
            op_data_pointer <= 16'hfff0;
            op_bit_addr <= (k == 3) ? 8'hf3 : 8'h20;
            exec(bbe_pkg::bbe_op_t'(o), 1'b0);
         end
      end
      reg_read(bbe_pkg::ADDR_SECOND_ACC, acc_model);
      $display("test operations done");
      exec(bbe_pkg::OP_SHORT_JUMP, 1'b1);
      exec(bbe_pkg::OP_CMP_IND_IMM, 1'b1);
      $display("test refused start done");
      summarize();
   end
endmodule
